// *** src/srcd_top.sv ***
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Sensor reference clock divider with APB registers
module srcd_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        fast_clk_tick,
  input  wire logic        sync_clock_mode,
  input  wire logic        ext_clock_detected,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sensor_reference_clock_out,
  output logic             osc_reference_active,
  output logic             osc_reference_range_select
);
  logic [2:0]  pdiv_r;      // fast_clock_predivider
  logic [2:0]  pdiv_nxt;
  logic [4:0]  num_r;       // ratio_numerator
  logic [4:0]  num_nxt;
  logic [7:0]  den_r;       // ratio_denominator
  logic [7:0]  den_nxt;
  logic        osc_r;       // Range select
  logic        osc_nxt;
  logic [2:0]  osclow_r;    // Low bits of oscillator register
  logic [2:0]  osclow_nxt;
  logic [4:0]  pcnt_r;      // Predivide counter
  logic [4:0]  pcnt_nxt;
  logic        ptick;       // Predivided tick
  logic [31:0] rdata_r;     // Registered read data
  logic [31:0] rdata_nxt;
  logic        err_r;
  logic        err_nxt;
  logic        acc_phase;   // Access phase
  logic        wr_en;
  logic [9:0]  idx;         // Word index
  logic        hit;
  logic        rclk;

  assign acc_phase = psel && penable;
  assign wr_en     = acc_phase && pwrite;
  assign idx       = paddr[11:srcd_pkg::SRCD_IDX_SHIFT];

  // Address decode
  always_comb begin
    hit = (idx == {2'b00, srcd_pkg::SRCD_IDX_OSC})
       || (idx == {2'b00, srcd_pkg::SRCD_IDX_CTRL0})
       || (idx == {2'b00, srcd_pkg::SRCD_IDX_CTRL1})
       || (idx == {2'b00, srcd_pkg::SRCD_IDX_STATUS});
  end

  // Register writes and read mux
  always_comb begin
    pdiv_nxt   = pdiv_r;
    num_nxt    = num_r;
    den_nxt    = den_r;
    osc_nxt    = osc_r;
    osclow_nxt = osclow_r;
    rdata_nxt  = 32'h0000_0000;
    err_nxt    = 1'b0;
    if (psel && !penable) begin
      // Setup phase: prepare answer
      err_nxt = !hit;
      unique case (1'b1)
        idx == {2'b00, srcd_pkg::SRCD_IDX_OSC}: begin
          rdata_nxt[srcd_pkg::SRCD_OSC_SEL_BIT] = osc_r;
          rdata_nxt[2:0] = osclow_r;
        end
        idx == {2'b00, srcd_pkg::SRCD_IDX_CTRL0}: begin
          rdata_nxt[srcd_pkg::SRCD_PDIV_HI:srcd_pkg::SRCD_PDIV_LO] = pdiv_r;
          rdata_nxt[srcd_pkg::SRCD_NUM_HI:srcd_pkg::SRCD_NUM_LO]   = num_r;
        end
        idx == {2'b00, srcd_pkg::SRCD_IDX_CTRL1}: begin
          rdata_nxt[7:0] = den_r;
        end
        idx == {2'b00, srcd_pkg::SRCD_IDX_STATUS}: begin
          rdata_nxt[0] = osc_reference_active;
          rdata_nxt[1] = rclk;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
    end
    if (wr_en) begin
      if (idx == {2'b00, srcd_pkg::SRCD_IDX_OSC}) begin
        osc_nxt    = pwdata[srcd_pkg::SRCD_OSC_SEL_BIT];
        osclow_nxt = pwdata[2:0];
      end
      if (idx == {2'b00, srcd_pkg::SRCD_IDX_CTRL0}) begin
        pdiv_nxt = pwdata[srcd_pkg::SRCD_PDIV_HI:srcd_pkg::SRCD_PDIV_LO];
        num_nxt  = pwdata[srcd_pkg::SRCD_NUM_HI:srcd_pkg::SRCD_NUM_LO];
      end
      if (idx == {2'b00, srcd_pkg::SRCD_IDX_CTRL1}) begin
        den_nxt = pwdata[7:0];
      end
    end
  end

  // Register state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdiv_r   <= srcd_pkg::SRCD_PDIV_RST;
      num_r    <= srcd_pkg::SRCD_NUM_RST;
      den_r    <= srcd_pkg::SRCD_DEN_RST;
      osc_r    <= srcd_pkg::SRCD_OSC_SEL_RST;
      osclow_r <= srcd_pkg::SRCD_OSC_LOW_RST;
      rdata_r  <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else begin
      pdiv_r   <= pdiv_nxt;
      num_r    <= num_nxt;
      den_r    <= den_nxt;
      osc_r    <= osc_nxt;
      osclow_r <= osclow_nxt;
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // No wait state: answer latched at setup, access ends at once
  assign pready  = 1'b1;
  assign prdata  = rdata_r;
  assign pslverr = acc_phase && err_r;

  // Predivide counter on fast clock ticks
  always_comb begin
    pcnt_nxt = pcnt_r;
    ptick    = 1'b0;
    if (fast_clk_tick) begin
      if (5'(pcnt_r + 5'h01) >= srcd_pkg::srcd_pdiv_ratio(pdiv_r)) begin
        pcnt_nxt = 5'h00;
        ptick    = 1'b1;
      end else begin
        pcnt_nxt = 5'(pcnt_r + 5'h01);
      end
    end
  end

  // Predivide counter register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcnt_r <= 5'h00;
    end else begin
      pcnt_r <= pcnt_nxt;
    end
  end

  // Ratio stage
  srcd_ratio_gen u_ratio (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (ptick),
    .num     (num_r),
    .den     (den_r),
    .clk_out (rclk)
  );

  assign sensor_reference_clock_out = rclk;
  // Oscillator used when not synchronous or no external clock
  assign osc_reference_active = !sync_clock_mode || !ext_clock_detected;
  assign osc_reference_range_select = osc_r;
endmodule : srcd_top

// *** common/srcd_pkg.sv ***
package srcd_pkg;
  // Printed offsets are not word multiples: kept as indices
  localparam logic [7:0] SRCD_IDX_CTRL0    = 8'h06;
  localparam logic [7:0] SRCD_IDX_CTRL1    = 8'h07;
  localparam logic [7:0] SRCD_IDX_OSC      = 8'h05;
  localparam logic [7:0] SRCD_IDX_STATUS   = 8'h08;
  localparam int         SRCD_IDX_SHIFT    = 2;
  // Field positions
  localparam int         SRCD_OSC_SEL_BIT  = 3;
  localparam int         SRCD_PDIV_HI      = 7;
  localparam int         SRCD_PDIV_LO      = 5;
  localparam int         SRCD_NUM_HI       = 4;
  localparam int         SRCD_NUM_LO       = 0;
  // Reset values
  localparam logic [2:0] SRCD_PDIV_RST     = 3'h2;
  localparam logic [4:0] SRCD_NUM_RST      = 5'h01;
  localparam logic [7:0] SRCD_DEN_RST      = 8'h28;
  localparam logic       SRCD_OSC_SEL_RST  = 1'h0;
  localparam logic [2:0] SRCD_OSC_LOW_RST  = 3'h3;
  // Largest defined predivide code
  localparam logic [2:0] SRCD_PDIV_MAX     = 3'h4;
  // Predivide ratio as a shift amount
  function automatic logic [4:0] srcd_pdiv_ratio(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h01;
    if (code <= SRCD_PDIV_MAX) begin
      r = 5'(5'h01 << code);
    end
    return r;
  endfunction : srcd_pdiv_ratio
endpackage : srcd_pkg

// *** src/srcd_ratio_gen.sv ***
`timescale 1ns/1ps
// Fractional M/N accumulator producing a square output
module srcd_ratio_gen (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic [4:0] num,
  input  wire logic [7:0] den,
  output logic            clk_out
);
  logic [8:0] acc_r;    // Phase accumulator
  logic [8:0] acc_nxt;  // Next accumulator
  logic       out_r;    // Output level
  logic       out_nxt;  // Next output level
  logic [9:0] sum;      // Phase plus twice numerator

  // Accumulate 2*M per tick; each wrap past N toggles output
  always_comb begin
    acc_nxt = acc_r;
    out_nxt = out_r;
    sum     = {1'b0, acc_r} + {4'h0, num, 1'b0};
    if (num == 5'h00) begin
      acc_nxt = 9'h000;
    end else if (den == 8'h00) begin
      acc_nxt = 9'h000;
    end else if (tick) begin
      if (sum >= {2'b00, den}) begin
        acc_nxt = 9'(sum - {2'b00, den});
        out_nxt = ~out_r;
      end else begin
        acc_nxt = sum[8:0];
      end
    end
  end

  // Register accumulator and output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_r <= 9'h000;
      out_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;
endmodule : srcd_ratio_gen

// *** dv/srcd_top_properties.sv ***
`timescale 1ns/1ps
// Port-level checks for the reference clock divider
module srcd_top_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        fast_clk_tick,
  input wire logic        sync_clock_mode,
  input wire logic        ext_clock_detected,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sensor_reference_clock_out,
  input wire logic        osc_reference_active,
  input wire logic        osc_reference_range_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Access phase of a write to one byte address
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  AST_OSC_ACT: assert property (osc_reference_active ==
    (!sync_clock_mode || !ext_clock_detected)) else $error("osc use");
  AST_STATUS: assert property (
    psel && !penable && !pwrite && paddr == 12'h020 |=>
    prdata[0] == $past(osc_reference_active)) else $error("status");
  AST_RANGE_WR: assert property (s_wr(12'h014) |=>
    osc_reference_range_select == $past(pwdata[3])) else $error("range");
  AST_RANGE_RST: assert property (disable iff (1'b0)
    rst |=> !osc_reference_range_select) else $error("range reset");
  AST_NUM_ZERO: assert property (
    s_wr(12'h018) ##0 pwdata[4:0] == 5'h00 |=> ##1
    $stable(sensor_reference_clock_out) [*8]) else $error("not static");
  AST_NO_TICK: assert property (!fast_clk_tick [*8] |=>
    $stable(sensor_reference_clock_out)) else $error("toggle");
  AST_SLVERR: assert property (psel && penable && paddr == 12'h040
    |-> pslverr) else $error("no error");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("no ready");
endmodule : srcd_top_properties
bind srcd_top srcd_top_properties u_props (.*);

// *** dv/srcd_sensor_model.sv ***
`timescale 1ns/1ps
// Sensor side: counts rising edges of the reference clock
module srcd_sensor_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ref_clk,
  output int        edges
);
  logic last;  // Level seen at previous sample
  // Sampled away from the launching edge; one process owns the count
  always @(negedge clk_sys) begin
    if (rst) begin
      edges <= 0;
      last  <= 1'b0;
    end else begin
      if (ref_clk && !last) edges <= edges + 1;
      last <= ref_clk;
    end
  end
endmodule : srcd_sensor_model

// *** dv/srcd_top_tb.sv ***
`timescale 1ns/1ps
// Register and clock-rate tests for the divider
module srcd_top_tb;
  logic        clk_sys, rst, tick, sync_m, ext_d, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, ref_out, osc_act, osc_rng, e;
  int          bad_count, checked, n_edge, n;
  srcd_top u_dut (.clk_sys, .rst, .fast_clk_tick(tick),
    .sync_clock_mode(sync_m), .ext_clock_detected(ext_d), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sensor_reference_clock_out(ref_out), .osc_reference_active(osc_act),
    .osc_reference_range_select(osc_rng));
  srcd_sensor_model u_sensor (.clk_sys, .rst, .ref_clk(ref_out),
    .edges(n_edge));
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task close_out;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Exact compare, tolerance one edge for rates
  task cmp(input string nm, input logic [31:0] ex, got, input int tol);
    checked++;
    if (got !== ex && (tol == 0 || got + 1 !== ex && got !== ex + 1)) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : cmp
  // One APB transfer, bounded wait on pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    if (k == 16) begin bad_count++; close_out; end
  endtask : apb
  // Program ctrl0 and denominator, count edges over 640 cycles
  task rate(input logic [7:0] c0, den, input int ex);
    apb(1, 12'h018, {24'h0, c0});
    apb(1, 12'h01c, {24'h0, den});
    repeat (20) @(posedge clk_sys);
    n = n_edge;
    repeat (640) @(posedge clk_sys);
    cmp("edges", ex, n_edge - n, ex != 0);
  endtask : rate
  initial begin
    rst = 1; tick = 0; sync_m = 1; ext_d = 1; psel = 0; penable = 0;
    pwrite = 0; paddr = 0; pwdata = 0; bad_count = 0; checked = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    apb(0, 12'h018, 0); cmp("ctrl0", 32'h41, q, 0);
    apb(0, 12'h01c, 0); cmp("den", 32'h28, q, 0);
    apb(0, 12'h014, 0); cmp("osc", 32'h03, q, 0);
    apb(0, 12'h040, 0); cmp("err", 1, {31'h0, e}, 0);
    apb(1, 12'h014, 32'h0b);
    @(posedge clk_sys);
    cmp("rng", 1, {31'h0, osc_rng}, 0);
    apb(0, 12'h014, 0); cmp("oscw", 32'h0b, q, 0);
    for (int i = 0; i < 4; i++) begin
      sync_m <= i[0]; ext_d <= i[1];
      apb(0, 12'h020, 0); cmp("act", {31'h0, !(i[0] && i[1])}, q, 0);
    end
    $display("test registers done");
    tick <= 1;
    for (int p = 0; p < 5; p++) rate({p[2:0], 5'h01}, 8'h02, 320 >> p);
    rate(8'h03, 8'h08, 240);
    apb(0, 12'h018, 0); cmp("num", 32'h03, q, 0);
    rate(8'h00, 8'h08, 0);
    apb(1, 12'h018, 32'hb1); apb(0, 12'h018, 0); cmp("rsv", 32'hb1, q, 0);
    tick <= 0;
    repeat (12) @(posedge clk_sys);
    $display("test clocks done");
    close_out;
  end
endmodule : srcd_top_tb
